/* File: verilog/kbext_pkg.sv */
// constants for the keyboard and external interrupt block
`default_nettype none
package kbext_pkg;
    // register byte addresses (printed offsets are not all multiples of four)
    localparam int unsigned        KBEXT_IDX_STATUS_CONTROL = 32'h0000001A;
    localparam int unsigned        KBEXT_IDX_PIN_ENABLE     = 32'h0000001B;
    localparam logic [7:0]         KBEXT_ADDR_STATUS_CONTROL = 8'h68;
    localparam logic [7:0]         KBEXT_ADDR_PIN_ENABLE     = 8'h6C;
    // status/control field positions
    localparam int unsigned        KBEXT_BIT_EXT_PEND  = 7;
    localparam int unsigned        KBEXT_BIT_EXT_ACK   = 6;
    localparam int unsigned        KBEXT_BIT_EXT_MASK  = 5;
    localparam int unsigned        KBEXT_BIT_EXT_SENS  = 4;
    localparam int unsigned        KBEXT_BIT_KEY_PEND  = 3;
    localparam int unsigned        KBEXT_BIT_KEY_ACK   = 2;
    localparam int unsigned        KBEXT_BIT_KEY_MASK  = 1;
    localparam int unsigned        KBEXT_BIT_KEY_SENS  = 0;
    // reset values
    localparam logic [7:0]         KBEXT_RST_STATUS_CONTROL = 8'h00;
    localparam logic [7:0]         KBEXT_RST_PIN_ENABLE     = 8'h00;
    // shared vector of both requests
    localparam logic [15:0]        KBEXT_VECTOR_HI_ADDR = 16'hFFFA;
    localparam logic [15:0]        KBEXT_VECTOR_LO_ADDR = 16'hFFFB;
    localparam int unsigned        KBEXT_NUM_KEYS = 6;
endpackage
`default_nettype wire

/* File: verilog/kbext_top.sv */
// keyboard and external interrupt block with avalon-mm register slave
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module kbext_top
    import kbext_pkg::*;
#(
    parameter int NUM_KEYS = KBEXT_NUM_KEYS
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic [7:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire logic [NUM_KEYS-1:0] key_pins,
    input  wire logic                external_interrupt_pin_n,
    input  wire logic                vector_fetch,
    input  wire logic                break_active,
    input  wire logic                break_clear_enable,
    input  wire logic [NUM_KEYS-1:0] port_direction_bits,
    output logic      [NUM_KEYS-1:0] key_pullup_en,
    output logic      [NUM_KEYS-1:0] key_pin_dir_out,
    output logic                     cpu_irq,
    output logic                     wake_req,
    output logic      [15:0]         irq_vector_addr
);

    // ------------------------------------------------------------
    // overview
    // ------------------------------------------------------------
    // two request latches, one per source, share one vector.
    // each latch sets on a falling edge of its synchronised pin, and in
    // edge-and-level mode also for as long as the pin stays low.
    // a clear comes from a software acknowledge or a vector fetch;
    // in edge-and-level mode it is only armed while the pin is low and
    // completes once the pin is back high.
    // a new set always wins over a clear in the same cycle, so an edge
    // that races an acknowledge is never lost.
    // the masks act only on the cpu request and the wakeup output, never on the latches or
    // the pending flags, so software can still poll with the masks set.
    // pin changes reach the latch three edges after they appear and the
    // cpu request follows combinationally; a pin pulse shorter than a
    // clock period may be missed.
    // no state here depends on the cpu clock running, so requests still
    // reach the wakeup output in wait and stop.

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // one wait cycle on every access: readdata is registered.
    // edge n: request seen with waitrequest high, read data captured,
    //         ack_q armed
    // edge n+1: waitrequest low, a write takes effect here and read data
    //           stand for the master to take
    // a master that keeps its request up after edge n+1 starts a new
    // access, so it must drop read or write at that edge
    // only byte lane 0 carries register bits; the upper lanes are ignored
    logic                ack_q;
    logic [31:0]         rdata_q;
    logic                ext_sens_q;
    logic                ext_mask_q;
    logic                key_sens_q;
    logic                key_mask_q;
    logic [NUM_KEYS-1:0] key_en_q;
    logic                ext_latch_q;
    logic                key_latch_q;
    logic                req_go;
    logic                wr_go;
    logic                sc_wr;
    logic                ie_wr;
    logic [7:0]          sc_read;

    assign req_go          = (avs_read | avs_write) & ~ack_q;
    assign wr_go           = avs_write & ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    // address decode, shared by the read path and the write strobes
    logic                sel_sc;
    logic                sel_pe;
    logic                lane0_wr;
    logic [31:0]         rd_mux;

    assign sel_sc       = (avs_address == KBEXT_ADDR_STATUS_CONTROL);
    assign sel_pe       = (avs_address == KBEXT_ADDR_PIN_ENABLE);
    assign lane0_wr     = wr_go & avs_byteenable[0];
    assign sc_wr        = lane0_wr & sel_sc;
    assign ie_wr        = lane0_wr & sel_pe;
    assign avs_readdata = rdata_q;

    // acks read as zero; pending flags show latches regardless of mask
    assign sc_read = {ext_latch_q, 1'b0, ext_mask_q, ext_sens_q,
                      key_latch_q, 1'b0, key_mask_q, key_sens_q};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_go;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h00000000;
        end else if (req_go & avs_read) begin
            rdata_q <= rd_mux;
        end
    end

    // unmapped addresses read zero; enables sit one bit up in the byte
    always_comb begin
        rd_mux = 32'h00000000;
        if (sel_sc) begin
            rd_mux = {24'h000000, sc_read};
        end else if (sel_pe) begin
            rd_mux = {{(32-NUM_KEYS-1){1'b0}}, key_en_q, 1'b0};
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // a status/control write stores sensitivity and masks only; the two
    // acknowledge bits are strobes and are never stored, which is why
    // they read back as zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_sens_q <= KBEXT_RST_STATUS_CONTROL[KBEXT_BIT_EXT_SENS];
            ext_mask_q <= KBEXT_RST_STATUS_CONTROL[KBEXT_BIT_EXT_MASK];
            key_sens_q <= KBEXT_RST_STATUS_CONTROL[KBEXT_BIT_KEY_SENS];
            key_mask_q <= KBEXT_RST_STATUS_CONTROL[KBEXT_BIT_KEY_MASK];
        end else if (sc_wr) begin
            ext_sens_q <= avs_writedata[KBEXT_BIT_EXT_SENS];
            ext_mask_q <= avs_writedata[KBEXT_BIT_EXT_MASK];
            key_sens_q <= avs_writedata[KBEXT_BIT_KEY_SENS];
            key_mask_q <= avs_writedata[KBEXT_BIT_KEY_MASK];
        end
    end

    // enable bit n sits at register bit n+1; register bits 0 and 7
    // have no storage behind them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_en_q <= KBEXT_RST_PIN_ENABLE[NUM_KEYS:1];
        end else if (ie_wr) begin
            key_en_q <= avs_writedata[NUM_KEYS:1];
        end
    end

    // ------------------------------------------------------------
    // pin control
    // ------------------------------------------------------------
    // enabled pins are inputs; otherwise direction follows the port.
    // the pin read path stays with the port logic, which still needs
    // its direction bit at zero to read the level
    for (genvar p = 0; p < NUM_KEYS; p++) begin : g_pin_ctl
        assign key_pullup_en[p]   = key_en_q[p];
        assign key_pin_dir_out[p] = port_direction_bits[p] & ~key_en_q[p];
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_KEYS-1:0] key_meta_q;
    logic [NUM_KEYS-1:0] key_sync_q;
    logic [NUM_KEYS-1:0] key_prev_q;
    logic                ext_meta_q;
    logic                ext_sync_q;
    logic                ext_prev_q;

    // flops reset to the released level so no false edge follows reset;
    // only the second stage and the previous copy feed the edge logic
    for (genvar k = 0; k < NUM_KEYS; k++) begin : g_key_sync
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                key_meta_q[k] <= 1'b1;
                key_sync_q[k] <= 1'b1;
                key_prev_q[k] <= 1'b1;
            end else begin
                key_meta_q[k] <= key_pins[k];
                key_sync_q[k] <= key_meta_q[k];
                key_prev_q[k] <= key_sync_q[k];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_meta_q <= 1'b1;
            ext_sync_q <= 1'b1;
            ext_prev_q <= 1'b1;
        end else begin
            ext_meta_q <= external_interrupt_pin_n;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // ------------------------------------------------------------
    // keyboard latch
    // ------------------------------------------------------------
    logic                any_key_low;
    logic                all_were_high;
    logic                key_fall;
    logic                key_set;
    logic                ack_allowed;
    logic                key_ack;
    logic                key_ack_sw;
    logic                ext_ack_sw;
    logic                key_pend_clr_q;
    logic                ext_fall;
    logic                ext_set;
    logic                ext_ack;
    logic                ext_pend_clr_q;

    // disabled pins count as high in both tests
    logic [NUM_KEYS-1:0] key_low_now;
    logic [NUM_KEYS-1:0] key_high_before;

    // per pin: a disabled pin reads as released now and before
    for (genvar j = 0; j < NUM_KEYS; j++) begin : g_key_gate
        assign key_low_now[j]     = ~key_sync_q[j] & key_en_q[j];
        assign key_high_before[j] = key_prev_q[j] | ~key_en_q[j];
    end

    assign any_key_low   = |key_low_now;
    assign all_were_high = &key_high_before;
    assign key_fall      = any_key_low & all_were_high;
    assign key_set       = key_fall | (key_sens_q & any_key_low);
    // acks are ignored in break unless clearing is allowed
    assign ack_allowed   = ~break_active | break_clear_enable;
    assign key_ack_sw    = sc_wr & avs_writedata[KBEXT_BIT_KEY_ACK];
    assign ext_ack_sw    = sc_wr & avs_writedata[KBEXT_BIT_EXT_ACK];
    // the shared vector acknowledges both sources at once; a latch
    // cleared during break stays cleared once break ends
    assign key_ack       = ack_allowed & (key_ack_sw | vector_fetch);

    // ack arms a pending clear that completes once pins are high (edge-level).
    // the arm survives while a pin is held low, so the two halves of the
    // clear may come in either order; a fresh falling edge after the ack
    // disarms it, so that new request waits for an ack of its own
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_pend_clr_q <= 1'b0;
        end else if (~key_sens_q) begin
            key_pend_clr_q <= 1'b0;
        end else if (key_ack) begin
            key_pend_clr_q <= 1'b1;
        end else if (key_fall | ~key_latch_q) begin
            key_pend_clr_q <= 1'b0;
        end
    end

    // set wins over clear so a new edge is never lost
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key_latch_q <= 1'b0;
        end else if (key_set) begin
            key_latch_q <= 1'b1;
        end else if (~key_sens_q & key_ack) begin
            key_latch_q <= 1'b0;
        end else if (key_sens_q & (key_ack | key_pend_clr_q)) begin
            key_latch_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // external latch
    // ------------------------------------------------------------
    assign ext_fall = ~ext_sync_q & ext_prev_q;
    assign ext_set  = ext_fall | (ext_sens_q & ~ext_sync_q);
    assign ext_ack  = ack_allowed & (ext_ack_sw | vector_fetch);

    // same arm-then-complete clear as the keyboard side, for one pin

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_pend_clr_q <= 1'b0;
        end else if (~ext_sens_q) begin
            ext_pend_clr_q <= 1'b0;
        end else if (ext_ack) begin
            ext_pend_clr_q <= 1'b1;
        end else if (ext_fall | ~ext_latch_q) begin
            ext_pend_clr_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_latch_q <= 1'b0;
        end else if (ext_set) begin
            ext_latch_q <= 1'b1;
        end else if (ext_ack | ext_pend_clr_q) begin
            ext_latch_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // cpu request, wakeup and vector
    // ------------------------------------------------------------
    logic key_irq;
    logic ext_irq;
    logic irq_d;

    // a masked source keeps its latch and flag, it only stops requesting
    assign key_irq = key_latch_q & ~key_mask_q;
    assign ext_irq = ext_latch_q & ~ext_mask_q;
    assign irq_d   = key_irq | ext_irq;

    // purely combinational from latches: works with cpu clocks gated in wait/stop.
    // the wakeup output is the same masked request; the core decides
    // whether it leaves wait or stop, this block only keeps asking
    assign cpu_irq         = irq_d;
    assign wake_req        = irq_d;
    assign irq_vector_addr = KBEXT_VECTOR_HI_ADDR;

endmodule
`default_nettype wire

/* File: verification/kbext_assertions.sv */
// port checker for the keyboard and external interrupt block
`timescale 1ns/1ps
`default_nettype none
module kbext_checker #(parameter int NUM_KEYS = 6) (
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic [7:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    input wire logic [NUM_KEYS-1:0] port_direction_bits,
    input wire logic [NUM_KEYS-1:0] key_pullup_en,
    input wire logic [NUM_KEYS-1:0] key_pin_dir_out,
    input wire logic                cpu_irq,
    input wire logic                wake_req,
    input wire logic [15:0]         irq_vector_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rdone;
    assign rdone = avs_read && !avs_waitrequest;
    a_vector_addr: assert property (irq_vector_addr == 16'hFFFA)
        else $error("vector address wrong");
    a_wake_follows: assert property (wake_req == cpu_irq)
        else $error("wake request differs from irq");
    a_dir_override: assert property (key_pin_dir_out == (port_direction_bits & ~key_pullup_en))
        else $error("enabled pin not forced to input");
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered in first cycle");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one cycle");
    a_ack_zero: assert property (rdone && avs_address == 8'h68 |->
        avs_readdata[31:8] == 24'h0 && !avs_readdata[6] && !avs_readdata[2])
        else $error("acknowledge bits read nonzero");
    a_enable_read: assert property (rdone && avs_address == 8'h6C |->
        avs_readdata == {24'h0, 1'b0, key_pullup_en, 1'b0}) else $error("enable readback wrong");
    a_reset_clears: assert property ($fell(sys_rst) |-> !cpu_irq && key_pullup_en == '0)
        else $error("state left after reset");
    cover property ($rose(cpu_irq));
    cover property ($fell(cpu_irq));
    cover property (avs_write && !avs_waitrequest);
endmodule
bind kbext_top kbext_checker #(.NUM_KEYS(NUM_KEYS)) u_chk (.clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .port_direction_bits,
    .key_pullup_en, .key_pin_dir_out, .cpu_irq, .wake_req, .irq_vector_addr);
`default_nettype wire

/* File: verification/kbext_keypad_model.sv */
// keypad switches and external interrupt source
`timescale 1ns/1ps
`default_nettype none
module kbext_keypad_model (
    input  wire logic       clk,
    input  wire logic [5:0] press,
    input  wire logic       ext_low,
    input  wire logic [5:0] pullup_en,
    output logic      [5:0] key_pins,
    output logic            ext_pin_n
);
    logic tog_q = 1'b0;
    always_ff @(posedge clk) tog_q <= ~tog_q;
    // a released pin with no pullup wanders, so the block must ignore it
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            key_pins[i] = press[i] ? 1'b0 : (pullup_en[i] ? 1'b1 : tog_q);
        end
    end
    assign ext_pin_n = ~ext_low;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// register-level testbench of the keyboard and external interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import kbext_pkg::*;
    localparam logic [7:0] SC = KBEXT_ADDR_STATUS_CONTROL;
    localparam logic [7:0] PE = KBEXT_ADDR_PIN_ENABLE;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, vector_fetch = 1'b0;
    logic break_active = 1'b0, break_clear_enable = 1'b0, ext_low = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    // pins start as outputs before their enables are set
    logic [5:0] press = 6'h00, port_direction_bits = 6'h3F, key_pins, key_pullup_en, key_pin_dir_out;
    logic irq_s;
    logic [5:0] pull_s, dir_s;
    logic avs_waitrequest, external_interrupt_pin_n, cpu_irq, wake_req;
    logic [15:0] irq_vector_addr;
    int error_cnt = 0, cmp_count = 0;
    always #25 clk = ~clk;
    // outputs are looked at mid-cycle, where they have settled
    always @(negedge clk) begin
        irq_s = cpu_irq;
        pull_s = key_pullup_en;
        dir_s = key_pin_dir_out;
    end
    kbext_top u_dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .key_pins,
        .external_interrupt_pin_n, .vector_fetch, .break_active, .break_clear_enable,
        .port_direction_bits, .key_pullup_en, .key_pin_dir_out, .cpu_irq, .wake_req,
        .irq_vector_addr);
    kbext_keypad_model u_pad (.clk, .press, .ext_low, .pullup_en(key_pullup_en), .key_pins,
        .ext_pin_n(external_interrupt_pin_n));
    // ------
    // bus tasks
    // ------
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [31:0] q);
        int n;
        logic wt;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= w;
        avs_read <= ~w;
        n = 0;
        // inputs move only after a rising edge, so the mid-cycle value holds at it
        do begin
            @(negedge clk);
            wt = avs_waitrequest;
            q = avs_readdata;
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (wt !== 1'b0) error_cnt++;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t ns: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        xfer(a, 1'b0, 8'h00, q);
        chk(q, {24'h0, e});
    endtask
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        error_cnt++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rc(SC, 8'h00);
        rc(PE, 8'h00);
        rc(8'h70, 8'h00);
        wr(SC, 8'h02);
        wr(PE, 8'h7E);
        chk({26'h0, pull_s}, 32'h3F);
        chk({26'h0, dir_s}, 32'h0);
        wr(SC, 8'h06);
        wr(SC, 8'h00);
        wr(8'h70, 8'hFF);
        rc(SC, 8'h00);
        press <= 6'h04;
        settle;
        rc(SC, 8'h08);
        chk({31'h0, irq_s}, 32'h1);
        wr(SC, 8'h02);
        chk({31'h0, irq_s}, 32'h0);
        rc(SC, 8'h0A);
        wr(SC, 8'h06);
        rc(SC, 8'h02);
        press <= 6'h0C;
        settle;
        rc(SC, 8'h02);
        press <= 6'h00;
        settle;
        press <= 6'h01;
        settle;
        rc(SC, 8'h0A);
        vector_fetch <= 1'b1;
        @(posedge clk);
        vector_fetch <= 1'b0;
        settle;
        rc(SC, 8'h02);
        press <= 6'h00;
        settle;
        wr(SC, 8'h03);
        press <= 6'h02;
        settle;
        wr(SC, 8'h07);
        rc(SC, 8'h0B);
        press <= 6'h00;
        settle;
        rc(SC, 8'h03);
        ext_low <= 1'b1;
        settle;
        rc(SC, 8'h83);
        chk({31'h0, irq_s}, 32'h1);
        wr(SC, 8'h23);
        chk({31'h0, irq_s}, 32'h0);
        wr(SC, 8'h63);
        rc(SC, 8'h23);
        ext_low <= 1'b0;
        break_active <= 1'b1;
        settle;
        ext_low <= 1'b1;
        settle;
        wr(SC, 8'h63);
        rc(SC, 8'hA3);
        break_clear_enable <= 1'b1;
        wr(SC, 8'h63);
        rc(SC, 8'h23);
        break_active <= 1'b0;
        ext_low <= 1'b0;
        wr(SC, 8'h33);
        settle;
        ext_low <= 1'b1;
        settle;
        wr(SC, 8'h73);
        rc(SC, 8'hB3);
        ext_low <= 1'b0;
        settle;
        rc(SC, 8'h33);
        press <= 6'h01;
        settle;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rc(SC, 8'h00);
        rc(PE, 8'h00);
        summarize;
    end
endmodule
`default_nettype wire
